// [logic/pmi_top.sv]
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
// Functional notes
// - PHY registers reachable only through the data and launch register pair.
// - Cycles aimed at the virtual PHY address are refused.
// - Data register is 32 bits; upper half reads zero, lower half is the word.
// - Read launched by the launch register; returned word lands in the data register.
// - Data read gives the PHY word if write select is 0, else the stored word.
// - Launch write starts a cycle; bits 15:11 PHY, 10:6 index, bit 1 write.
// - Busy bit 0 sets on launch, holds during the cycle, clears at completion.
module pmi_top
  import pmi_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Management pins toward the internal PHYs
  output logic             mdc,
  output logic             mdio_o,
  output logic             mdio_oe,
  input  wire logic        mdio_i
);

  function automatic logic hits(input logic [31:0] addr, input logic [7:0] ofs);
    hits = (addr == {24'h000000, ofs});
  endfunction

  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [15:0] sw_word_reg, sw_word_next;
  logic [15:0] phy_word_reg, phy_word_next;
  pmi_acc_t    acc_reg, acc_next;
  logic        busy_reg, busy_next;

  logic        setup;
  logic        access;
  logic        hit_data;
  logic        hit_launch;
  logic        vphy_hit;
  logic        launch;
  pmi_acc_t    wr_acc;
  logic        eng_done;
  logic [15:0] eng_rdata;
  logic [15:0] data_view;

  assign setup      = psel && !penable;
  assign access     = psel && penable && pready_reg;
  // Only two words decoded; PHY registers have no direct window
  assign hit_data   = hits(paddr, PHY_MGMT_DATA_WORD_OFS);
  assign hit_launch = hits(paddr, PMI_LAUNCH_OFS);
  assign wr_acc     = '{phy_addr:          pwdata[PMI_PHY_HI:PMI_PHY_LO],
                        target_reg_index:  pwdata[PMI_IDX_HI:PMI_IDX_LO],
                        mgmt_write_select: pwdata[PMI_WSEL_BIT]};
  assign vphy_hit   = (wr_acc.phy_addr == PMI_VPHY_ADDR);
  // Launches during busy are dropped; the frame in flight owns the fields
  assign launch     = access && pwrite && hit_launch && !busy_reg
                      && !vphy_hit && pstrb[1];
  assign data_view  = acc_reg.mgmt_write_select ? sw_word_reg : phy_word_reg;

  // APB answer is prepared in the setup cycle so outputs come from flops
  always_comb
  begin
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (setup)
    begin
      pready_next = 1'b1;
      prdata_next = '0;
      if (hit_data)
        prdata_next = {16'h0000, data_view};
      else if (hit_launch)
      begin
        prdata_next[PMI_PHY_HI:PMI_PHY_LO] = acc_reg.phy_addr;
        prdata_next[PMI_IDX_HI:PMI_IDX_LO] = acc_reg.target_reg_index;
        prdata_next[PMI_WSEL_BIT]          = acc_reg.mgmt_write_select;
        prdata_next[PMI_BUSY_BIT]          = busy_reg;
      end
      else
        pslverr_next = 1'b1;
      if (pwrite && hit_launch && !busy_reg && vphy_hit)
        pslverr_next = 1'b1;
    end
  end

  // Register state
  always_comb
  begin
    sw_word_next  = sw_word_reg;
    phy_word_next = phy_word_reg;
    acc_next      = acc_reg;
    busy_next     = busy_reg;
    if (access && pwrite && hit_data && !busy_reg)
    begin
      if (pstrb[0])
        sw_word_next[7:0] = pwdata[7:0];
      if (pstrb[1])
        sw_word_next[15:8] = pwdata[15:8];
    end
    if (launch)
    begin
      acc_next  = wr_acc;
      busy_next = 1'b1;
    end
    if (eng_done)
    begin
      busy_next = 1'b0;
      if (!acc_reg.mgmt_write_select)
        phy_word_next = eng_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg   <= '0;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      sw_word_reg  <= PHY_MGMT_DATA_WORD_RST[15:0];
      phy_word_reg <= PHY_MGMT_DATA_WORD_RST[15:0];
      acc_reg      <= '0;
      busy_reg     <= 1'b0;
    end
    else
    begin
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      sw_word_reg  <= sw_word_next;
      phy_word_reg <= phy_word_next;
      acc_reg      <= acc_next;
      busy_reg     <= busy_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  pmi_mdio_engine u_engine (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (launch),
    .acc     (wr_acc),
    .wdata   (sw_word_reg),
    .done    (eng_done),
    .rdata   (eng_rdata),
    .mdc     (mdc),
    .mdio_o  (mdio_o),
    .mdio_oe (mdio_oe),
    .mdio_i  (mdio_i)
  );

  // Helper: cycles spent busy, for the frame length check
  logic [13:0] busy_cnt_reg, busy_cnt_next;

  always_comb
  begin
    busy_cnt_next = busy_reg ? busy_cnt_reg + 14'h0001 : 14'h0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_cnt_reg <= '0;
    else
      busy_cnt_reg <= busy_cnt_next;
  end

  // Helper: cycles since the management clock last changed level
  logic       mdc_dly_reg, mdc_dly_next;
  logic [7:0] half_cnt_reg, half_cnt_next;

  always_comb
  begin
    mdc_dly_next  = mdc;
    half_cnt_next = (mdc != mdc_dly_reg) ? 8'h01 : half_cnt_reg + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mdc_dly_reg  <= 1'b0;
      half_cnt_reg <= '0;
    end
    else
    begin
      mdc_dly_reg  <= mdc_dly_next;
      half_cnt_reg <= half_cnt_next;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_busy_on_launch: assert property (
    launch |=> busy_reg && acc_reg == $past(wr_acc))
    else $error("busy not set after launch");

  chk_busy_clears: assert property (
    eng_done |=> !busy_reg)
    else $error("busy still set after frame end");

  chk_frame_length: assert property (
    eng_done |-> busy_reg && busy_cnt_reg == 14'(PMI_FRAME_CYC))
    else $error("frame length wrong");

  chk_read_capture: assert property (
    eng_done && !acc_reg.mgmt_write_select |=> phy_word_reg == $past(eng_rdata))
    else $error("read word not captured");

  chk_data_readback: assert property (
    setup && !pwrite && hit_data |=>
      prdata_reg[15:0] == ($past(acc_reg.mgmt_write_select) ?
                           $past(sw_word_reg) : $past(phy_word_reg)))
    else $error("data readback source wrong");

  chk_upper_zero: assert property (
    setup && hit_data |=> pready_reg && prdata_reg[31:16] == 16'h0000)
    else $error("data upper half not zero");

  chk_vphy_refused: assert property (
    setup && pwrite && hit_launch && !busy_reg && vphy_hit
      |=> pslverr_reg ##1 !busy_reg)
    else $error("virtual PHY cycle not refused");

  chk_launch_source: assert property (
    launch |-> pwrite && hit_launch && $past(setup))
    else $error("launch without launch register write");

  chk_sw_word_hold: assert property (
    busy_reg && $stable(busy_reg) |=> $stable(sw_word_reg))
    else $error("data word changed during cycle");

  chk_pready_pulse: assert property (
    pready_reg |=> !pready_reg)
    else $error("ready held longer than one cycle");

  chk_err_with_ready: assert property (
    pslverr_reg |-> pready_reg)
    else $error("error flag without ready");

  chk_unmapped_err: assert property (
    setup && !hit_data && !hit_launch |=> pslverr_reg && prdata_reg == 32'h0000_0000)
    else $error("unmapped access not refused");

  chk_launch_readback: assert property (
    setup && !pwrite && hit_launch |=>
      prdata_reg == {16'h0000, $past(acc_reg.phy_addr), $past(acc_reg.target_reg_index),
                     4'h0, $past(acc_reg.mgmt_write_select), $past(busy_reg)})
    else $error("launch register readback wrong");

  chk_busy_drops_launch: assert property (
    access && pwrite && hit_launch && busy_reg |=> $stable(acc_reg))
    else $error("launch accepted while busy");

  chk_busy_drops_data: assert property (
    access && pwrite && hit_data && busy_reg |=> $stable(sw_word_reg))
    else $error("data word written while busy");

  chk_vphy_no_start: assert property (
    launch |-> wr_acc.phy_addr != PMI_VPHY_ADDR)
    else $error("frame started toward virtual PHY");

  chk_pins_idle: assert property (
    !busy_reg |-> !mdc && !mdio_oe)
    else $error("management pins active while idle");

  chk_frame_starts: assert property (
    launch |=> mdio_oe && mdio_o && !mdc)
    else $error("frame did not start with driven preamble");

  chk_mdc_high_time: assert property (
    mdc_dly_reg && !mdc |-> half_cnt_reg == 8'(PMI_MDC_HALF_CYC))
    else $error("management clock high time wrong");

  chk_write_drives: assert property (
    busy_reg && acc_reg.mgmt_write_select && !eng_done |-> mdio_oe)
    else $error("data line released during write frame");

  chk_done_ends_frame: assert property (
    eng_done |-> !mdc && !mdio_oe)
    else $error("pins still active at frame end");

  cov_read: cover property (eng_done && !acc_reg.mgmt_write_select);
  cov_write: cover property (eng_done && acc_reg.mgmt_write_select);
  cov_vphy: cover property (setup && pwrite && hit_launch && vphy_hit && !busy_reg);
  cov_readback_sw: cover property (setup && hit_data && acc_reg.mgmt_write_select);
  cov_busy_drop: cover property (access && pwrite && hit_launch && busy_reg);

endmodule

// [logic/pmi_pkg.sv]
package pmi_pkg;

  // Register map, byte addresses
  localparam logic [7:0]  PHY_MGMT_DATA_WORD_OFS     = 8'ha4;
  localparam logic [7:0]  PMI_LAUNCH_OFS   = 8'ha8;
  localparam logic [31:0] PHY_MGMT_DATA_WORD_RST     = 32'h0000_0000;

  // Launch register fields
  localparam int PMI_PHY_HI   = 15;
  localparam int PMI_PHY_LO   = 11;
  localparam int PMI_IDX_HI   = 10;
  localparam int PMI_IDX_LO   = 6;
  localparam int PMI_WSEL_BIT = 1;
  localparam int PMI_BUSY_BIT = 0;

  // Management frame layout
  localparam logic [31:0] PMI_PREAMBLE   = 32'hffff_ffff;
  localparam logic [1:0]  PMI_ST         = 2'h1;
  localparam logic [1:0]  PMI_OP_WR      = 2'h1;
  localparam logic [1:0]  PMI_OP_RD      = 2'h2;
  localparam logic [1:0]  PMI_TA_WR      = 2'h2;
  localparam logic [5:0]  PMI_BIT_LAST   = 6'h3f;
  localparam logic [5:0]  PMI_TA_POS     = 6'h2e;
  localparam logic [5:0]  PHY_MGMT_DATA_WORD_POS   = 6'h30;
  localparam int          PMI_FRAME_BITS = 64;

  // Management clock: least high and low time each
  localparam int PMI_CLK_NS      = 4;
  localparam int PMI_MDC_HALF_NS = 200;
  localparam int PMI_MDC_HALF_CYC = (PMI_MDC_HALF_NS + PMI_CLK_NS - 1) / PMI_CLK_NS;
  localparam int PMI_FRAME_CYC   = 2 * PMI_FRAME_BITS * PMI_MDC_HALF_CYC;

  // Address of the virtual PHY, which is not reachable here
  localparam logic [4:0] PMI_VPHY_ADDR = 5'h00;

  typedef struct packed {
    logic [4:0] phy_addr;
    logic [4:0] target_reg_index;
    logic       mgmt_write_select;
  } pmi_acc_t;

  typedef enum logic [0:0] {
    PMI_IDLE = 1'b0,
    PMI_RUN  = 1'b1
  } pmi_state_t;

endpackage

// [logic/pmi_mdio_engine.sv]
`timescale 1ns/10ps
module pmi_mdio_engine
  import pmi_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Command side
  input  wire logic        start,
  input  wire pmi_acc_t    acc,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // Management pins toward the internal PHYs
  output logic             mdc,
  output logic             mdio_o,
  output logic             mdio_oe,
  input  wire logic        mdio_i
);

  pmi_state_t  state_reg, state_next;
  logic [63:0] frame_reg, frame_next;
  logic [5:0]  bit_reg, bit_next;
  logic [7:0]  div_reg, div_next;
  logic        mdc_reg, mdc_next;
  logic        out_reg, out_next;
  logic        oe_reg, oe_next;
  logic        wr_reg, wr_next;
  logic        done_reg, done_next;
  logic [15:0] rd_reg, rd_next;
  logic        tick;

  assign tick = (div_reg == 8'(PMI_MDC_HALF_CYC - 1));

  always_comb
  begin
    state_next = state_reg;
    frame_next = frame_reg;
    bit_next   = bit_reg;
    div_next   = div_reg;
    mdc_next   = mdc_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    wr_next    = wr_reg;
    done_next  = 1'b0;
    rd_next    = rd_reg;
    case (state_reg)
      PMI_IDLE:
      begin
        if (start)
        begin
          frame_next = {PMI_PREAMBLE, PMI_ST,
                        acc.mgmt_write_select ? PMI_OP_WR : PMI_OP_RD,
                        acc.phy_addr, acc.target_reg_index, PMI_TA_WR, wdata};
          bit_next   = '0;
          div_next   = '0;
          mdc_next   = 1'b0;
          out_next   = 1'b1;
          oe_next    = 1'b1;
          wr_next    = acc.mgmt_write_select;
          state_next = PMI_RUN;
        end
      end
      PMI_RUN:
      begin
        div_next = tick ? 8'h00 : div_reg + 8'h01;
        if (tick)
        begin
          mdc_next = ~mdc_reg;
          if (!mdc_reg && !wr_reg && bit_reg >= PHY_MGMT_DATA_WORD_POS)
            rd_next = {rd_reg[14:0], mdio_i};
          if (mdc_reg)
          begin
            if (bit_reg == PMI_BIT_LAST)
            begin
              // Busy falls only after the last data bit
              state_next = PMI_IDLE;
              oe_next    = 1'b0;
              out_next   = 1'b0;
              done_next  = 1'b1;
            end
            else
            begin
              bit_next   = bit_reg + 6'h01;
              frame_next = {frame_reg[62:0], 1'b0};
              out_next   = frame_reg[62];
              // Release the line at turnaround of a read
              oe_next    = wr_reg || (bit_reg + 6'h01 < PMI_TA_POS);
            end
          end
        end
      end
      default:
        state_next = PMI_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= PMI_IDLE;
      frame_reg <= '0;
      bit_reg   <= '0;
      div_reg   <= '0;
      mdc_reg   <= 1'b0;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      done_reg  <= 1'b0;
      rd_reg    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      frame_reg <= frame_next;
      bit_reg   <= bit_next;
      div_reg   <= div_next;
      mdc_reg   <= mdc_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      wr_reg    <= wr_next;
      done_reg  <= done_next;
      rd_reg    <= rd_next;
    end
  end

  assign done    = done_reg;
  assign rdata   = rd_reg;
  assign mdc     = mdc_reg;
  assign mdio_o  = out_reg;
  assign mdio_oe = oe_reg;

endmodule

// [verification/pmi_phy_model.sv]
`timescale 1ns/10ps
module pmi_phy_model
(
  // Clock and management pins
  input  wire logic        pclk,
  input  wire logic        mdc,
  input  wire logic        mdio_o,
  input  wire logic        mdio_oe,
  output logic             mdio_i,
  // Read word and captured frame
  input  wire logic [15:0] rd_word,
  output logic [63:0]      frame,
  output int               nfr
);
  int   cnt;
  logic drv;

  initial
  begin
    mdio_i = 1'b0;
    frame  = '0;
    nfr    = 0;
    cnt    = 0;
    drv    = 1'b0;
  end

  always @(posedge mdc)
  begin
    frame = {frame[62:0], mdio_oe ? mdio_o : mdio_i};
    cnt   = cnt + 1;
    if (cnt == 64)
    begin
      nfr = nfr + 1;
      cnt = 0;
    end
  end

  // Turnaround zero, then the word MSB first
  always @(negedge mdc)
  begin
    drv = (cnt >= 47) && !mdio_oe;
    if (drv)
      mdio_i = (cnt == 47) ? 1'b0 : rd_word[63-cnt];
  end

  // Released line toggles so a stale bit cannot pass as data
  always @(posedge pclk)
    if (!drv)
      mdio_i <= ~mdio_i;
endmodule

// [verification/test_phy_mgmt_indirect_access.sv]
`timescale 1ns/10ps
module test_phy_mgmt_indirect_access;
  import pmi_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mdc;
  logic        mdio_o;
  logic        mdio_oe;
  logic        mdio_i;
  logic [15:0] rd_word;
  logic [63:0] frame;
  int          nfr;
  int          err_total;
  int          tests_run;
  int          seed;
  int          cyc;
  int          t0;
  int          k;
  logic [31:0] r;
  logic        e;
  logic        wsel;
  logic [4:0]  phy;
  logic [4:0]  idx;
  logic [31:0] wd;
  logic [15:0] ref_word;

  pmi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mdc(mdc), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdio_i(mdio_i));
  pmi_phy_model phy_m (.pclk(pclk), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .mdio_i(mdio_i), .rd_word(rd_word), .frame(frame), .nfr(nfr));

  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is judged at the rising edge where the slave takes the access
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      err_total++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls busy bit 0 of the launch register until it reads 0, at most 4000 reads
  task wait_idle;
    int n;
    for (n = 0; n < 4000; n++)
    begin
      apb(1'b0, PMI_LAUNCH_OFS, 32'h0);
      if (r[0] === 1'b0)
        break;
    end
    if (n == 4000)
    begin
      err_total++;
      print_verdict();
    end
  endtask

  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; rd_word = 0; cyc = 0;
    err_total = 0; tests_run = 0; seed = 32'h9d6e9673; ref_word = 16'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PHY_MGMT_DATA_WORD_OFS, 32'h0);
    chk(r, PHY_MGMT_DATA_WORD_RST);
    apb(1'b0, PMI_LAUNCH_OFS, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 32'h1f4, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    apb(1'b1, 32'h200, 32'h1234);
    chk(e, 1'b1);
    apb(1'b1, PMI_LAUNCH_OFS, {16'h0, PMI_VPHY_ADDR, 5'h3, 6'h2});
    chk(e, 1'b1);
    apb(1'b0, PMI_LAUNCH_OFS, 32'h0);
    chk(r[0], 1'b0);
    for (k = 0; k < 4; k++)
    begin
      wsel = ~k[0];
      phy = $random(seed);
      if (phy == PMI_VPHY_ADDR)
        phy = 5'h1;
      idx = $random(seed);
      wd = $random(seed);
      rd_word = $random(seed);
      apb(1'b1, PHY_MGMT_DATA_WORD_OFS, wd);
      apb(1'b1, PMI_LAUNCH_OFS, {16'h0, phy, idx, 4'h0, wsel, 1'b0});
      t0 = cyc;
      apb(1'b0, PMI_LAUNCH_OFS, 32'h0);
      chk(r, {16'h0, phy, idx, 4'h0, wsel, 1'b1});
      // Writes while busy must leave the running frame alone
      apb(1'b1, PHY_MGMT_DATA_WORD_OFS, ~wd);
      apb(1'b1, PMI_LAUNCH_OFS, {16'h0, phy, idx, 6'h0});
      chk(e, 1'b0);
      wait_idle();
      chk((cyc - t0 >= PMI_FRAME_CYC) && (cyc - t0 <= PMI_FRAME_CYC + 12), 1'b1);
      ref_word = wsel ? wd[15:0] : rd_word;
      // Turnaround of a read is not driven by the block
      chk({frame[63:18], wsel ? frame[17:16] : 2'b10, frame[15:0]},
        {32'hffffffff, 2'b01, wsel ? 2'b01 : 2'b10, phy, idx, 2'b10, ref_word});
      chk(nfr, k + 1);
      apb(1'b0, PHY_MGMT_DATA_WORD_OFS, 32'h0);
      chk(r, {16'h0, ref_word});
    end
    print_verdict();
  end
endmodule
